/* verilog/interp_cfg_pkg.sv */
// Notes on behaviour
// - Separate six-bit offset trim per channel
// - Trim is sign-magnitude, top bit negative
// - One magnitude unit equals 13 mV step
// - Both zeros no correction, extremes 31 steps
// - Trim fields default from nonvolatile setting
// - Mode field bits 1:0 at 0x01
// - Modes 0-2 incremental, 3 commutation
// - Direction bit inverts count in inc/dir
// - Resolution code sets steps, zero means 256
package interp_cfg_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_RES = 8'h02;
  localparam logic [7:0] ADDR_OFS_A = 8'h08;
  localparam logic [7:0] ADDR_OFS_B = 8'h09;
  localparam int MODE_LSB = 0;
  localparam int DIR_BIT = 2;
  localparam int TRIM_SIGN_BIT = 5;
  localparam int TRIM_W = 6;
  localparam int STEP_UV = 13000;
  localparam logic [8:0] STEPS_ZERO_CODE = 9'h100;
  typedef enum logic [1:0] {
    MODE_QUAD = 2'b00,
    MODE_UPDN = 2'b01,
    MODE_INCDIR = 2'b10,
    MODE_COMM = 2'b11
  } out_mode_type;
  typedef struct packed {
    logic neg;
    logic [4:0] mag;
  } trim_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
endpackage

/* verilog/interpolator_output_config.sv */
`timescale 1ns/1ps
module interpolator_output_config (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire interp_cfg_pkg::bus_req_type bus_in,
  input wire logic [7:0] nv_mode_in,
  input wire logic [7:0] nv_res_in,
  input wire logic [5:0] nv_ofs_a_in,
  input wire logic [5:0] nv_ofs_b_in,
  output logic [7:0] rdata_out,
  output interp_cfg_pkg::out_mode_type mode_out,
  output logic incremental_out,
  output logic commutation_out,
  output logic dir_invert_out,
  output logic [8:0] steps_out,
  output logic signed [15:0] ofs_a_uv_div_out,
  output logic signed [15:0] ofs_b_uv_div_out,
  output logic signed [5:0] ofs_a_steps_out,
  output logic signed [5:0] ofs_b_steps_out
);
  logic [7:0] mode_reg;
  logic [7:0] res_reg;
  logic [5:0] ofs_a;
  logic [5:0] ofs_b;
  logic [7:0] next_rdata;

  function automatic logic signed [5:0] trim_steps(input logic [5:0] code);
    interp_cfg_pkg::trim_type t;
    t = code;
    // Negative zero folds to zero
    trim_steps = t.neg ? -$signed({1'b0, t.mag}) : $signed({1'b0, t.mag});
  endfunction

  // Nonvolatile values are sampled at reset, then software may overwrite
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode_reg <= nv_mode_in;
    end else if (bus_in.wr && bus_in.addr == interp_cfg_pkg::ADDR_MODE) begin
      mode_reg <= bus_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      res_reg <= nv_res_in;
    end else if (bus_in.wr && bus_in.addr == interp_cfg_pkg::ADDR_RES) begin
      res_reg <= bus_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ofs_a <= nv_ofs_a_in;
      ofs_b <= nv_ofs_b_in;
    end else if (bus_in.wr) begin
      if (bus_in.addr == interp_cfg_pkg::ADDR_OFS_A) begin
        ofs_a <= bus_in.wdata[5:0];
      end
      if (bus_in.addr == interp_cfg_pkg::ADDR_OFS_B) begin
        ofs_b <= bus_in.wdata[5:0];
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (bus_in.addr)
      interp_cfg_pkg::ADDR_MODE: next_rdata = mode_reg;
      interp_cfg_pkg::ADDR_RES: next_rdata = res_reg;
      interp_cfg_pkg::ADDR_OFS_A: next_rdata = {2'b00, ofs_a};
      interp_cfg_pkg::ADDR_OFS_B: next_rdata = {2'b00, ofs_b};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= bus_in.rd ? next_rdata : 8'h00;
    end
  end

  // Outputs lag the registers by one cycle so all come from flip-flops
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode_out <= interp_cfg_pkg::MODE_QUAD;
    end else begin
      mode_out <= interp_cfg_pkg::out_mode_type'(mode_reg[1:0]);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      commutation_out <= 1'b0;
    end else begin
      commutation_out <= (mode_reg[1:0] == interp_cfg_pkg::MODE_COMM);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      incremental_out <= 1'b0;
    end else begin
      incremental_out <= (mode_reg[1:0] != interp_cfg_pkg::MODE_COMM);
    end
  end

  // Direction only matters in inc/dir mode
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dir_invert_out <= 1'b0;
    end else begin
      dir_invert_out <= (mode_reg[1:0] == interp_cfg_pkg::MODE_INCDIR)
        && mode_reg[interp_cfg_pkg::DIR_BIT];
    end
  end

  // Commutation relies on software choosing code zero; not enforced here
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      steps_out <= interp_cfg_pkg::STEPS_ZERO_CODE;
    end else begin
      steps_out <= (res_reg == 8'h00) ? interp_cfg_pkg::STEPS_ZERO_CODE : {1'b0, res_reg};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ofs_a_steps_out <= 6'sh00;
      ofs_b_steps_out <= 6'sh00;
      ofs_a_uv_div_out <= 16'sh0000;
      ofs_b_uv_div_out <= 16'sh0000;
    end else begin
      ofs_a_steps_out <= trim_steps(ofs_a);
      ofs_b_steps_out <= trim_steps(ofs_b);
      // Correction in units of 1/10 mV to fit 16 bits: 13 mV is 130
      ofs_a_uv_div_out <= 16'(trim_steps(ofs_a) * (interp_cfg_pkg::STEP_UV / 100));
      ofs_b_uv_div_out <= 16'(trim_steps(ofs_b) * (interp_cfg_pkg::STEP_UV / 100));
    end
  end

  a_trim_sign_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in)
    |-> (ofs_a_steps_out < 0) == ($past(ofs_a[5]) && $past(ofs_a[4:0]) != 5'h00)
  ) else begin
    $error("channel A trim sign wrong");
  end

  a_trim_sign_b: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in)
    |-> (ofs_b_steps_out < 0) == ($past(ofs_b[5]) && $past(ofs_b[4:0]) != 5'h00)
  ) else begin
    $error("channel B trim sign wrong");
  end

  a_trim_zero_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(ofs_a[4:0]) == 5'h00
    |-> ofs_a_steps_out == 0
  ) else begin
    $error("channel A zero code not neutral");
  end

  a_trim_zero_b: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(ofs_b[4:0]) == 5'h00
    |-> ofs_b_steps_out == 0
  ) else begin
    $error("channel B zero code not neutral");
  end

  a_trim_max_neg: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(ofs_a) == 6'h3F
    |-> ofs_a_steps_out == -31
  ) else begin
    $error("largest negative trim wrong");
  end

  a_trim_max_pos: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(ofs_a) == 6'h1F
    |-> ofs_a_steps_out == 31
  ) else begin
    $error("largest positive trim wrong");
  end

  a_trim_step_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in)
    |-> ofs_a_uv_div_out == 16'(ofs_a_steps_out * (interp_cfg_pkg::STEP_UV / 100))
  ) else begin
    $error("channel A step size wrong");
  end

  a_trim_step_b: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in)
    |-> ofs_b_uv_div_out == 16'(ofs_b_steps_out * (interp_cfg_pkg::STEP_UV / 100))
  ) else begin
    $error("channel B step size wrong");
  end

  a_trim_write_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_in.wr && bus_in.addr == interp_cfg_pkg::ADDR_OFS_A
    |=> ofs_a == $past(bus_in.wdata[5:0])
  ) else begin
    $error("channel A trim write lost");
  end

  a_trim_write_b: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_in.wr && bus_in.addr == interp_cfg_pkg::ADDR_OFS_B
    |=> ofs_b == $past(bus_in.wdata[5:0])
  ) else begin
    $error("channel B trim write lost");
  end

  a_trim_read_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_in.rd && bus_in.addr == interp_cfg_pkg::ADDR_OFS_A
    |=> rdata_out[7:6] == 2'b00
  ) else begin
    $error("channel A upper trim bits nonzero");
  end

  a_trim_read_b: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_in.rd && bus_in.addr == interp_cfg_pkg::ADDR_OFS_B
    |=> rdata_out[7:6] == 2'b00
  ) else begin
    $error("channel B upper trim bits nonzero");
  end

  a_mode_sel: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_in.wr && bus_in.addr == interp_cfg_pkg::ADDR_MODE
    |-> ##2 mode_out == $past(bus_in.wdata[1:0], 2)
  ) else begin
    $error("mode not applied");
  end

  a_mode_kind: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in)
    |-> commutation_out == (mode_out == interp_cfg_pkg::MODE_COMM) && incremental_out != commutation_out
  ) else begin
    $error("mode kind wrong");
  end

  a_dir_gate: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    dir_invert_out
    |-> mode_out == interp_cfg_pkg::MODE_INCDIR
  ) else begin
    $error("direction outside inc/dir");
  end

  a_dir_follow: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(mode_reg[1:0]) == 2'b10
    |-> dir_invert_out == $past(mode_reg[interp_cfg_pkg::DIR_BIT])
  ) else begin
    $error("direction bit not followed");
  end

  a_res_zero: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(res_reg) == 8'h00
    |-> steps_out == 9'h100
  ) else begin
    $error("zero code not 256");
  end

  a_res_direct: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(res_reg) != 8'h00
    |-> steps_out == {1'b0, $past(res_reg)}
  ) else begin
    $error("steps differ from code");
  end

  a_res_write: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_in.wr && bus_in.addr == interp_cfg_pkg::ADDR_RES
    |=> res_reg == $past(bus_in.wdata)
  ) else begin
    $error("resolution write lost");
  end

  // Startup loads are checked without the reset guard
  a_reset_load_a: assert property (
    @(posedge sys_clk_in)
    rst_in
    |=> ofs_a == $past(nv_ofs_a_in)
  ) else begin
    $error("channel A nonvolatile load missing");
  end

  a_reset_load_b: assert property (
    @(posedge sys_clk_in)
    rst_in
    |=> ofs_b == $past(nv_ofs_b_in)
  ) else begin
    $error("channel B nonvolatile load missing");
  end

  a_reset_mode: assert property (
    @(posedge sys_clk_in)
    rst_in
    |=> mode_reg == $past(nv_mode_in)
  ) else begin
    $error("mode nonvolatile load missing");
  end

  a_reset_res: assert property (
    @(posedge sys_clk_in)
    rst_in
    |=> res_reg == $past(nv_res_in)
  ) else begin
    $error("resolution nonvolatile load missing");
  end

  c_comm: cover property (
    @(posedge sys_clk_in) commutation_out && steps_out == 9'h100
  );

  c_dir: cover property (
    @(posedge sys_clk_in) dir_invert_out
  );

  c_neg_max: cover property (
    @(posedge sys_clk_in) ofs_a_steps_out == -6'sd31
  );

  c_pos_max: cover property (
    @(posedge sys_clk_in) ofs_a_steps_out == 6'sd31
  );

  c_res_min: cover property (
    @(posedge sys_clk_in) steps_out == 9'h001
  );
endmodule // interpolator_output_config

/* tb/motor_counter_model.sv */
`timescale 1ns/1ps
module motor_counter_model (
  input wire interp_cfg_pkg::out_mode_type mode_in,
  input wire logic [8:0] steps_in,
  output logic comm_ok_out
);
  // Commutation only turns the motor at 256 steps; any other count stalls it
  always_comb begin
    comm_ok_out = (mode_in != interp_cfg_pkg::MODE_COMM) || (steps_in == 9'h100);
  end
endmodule // motor_counter_model

/* tb/interpolator_output_config_test.sv */
`timescale 1ns/1ps
module interpolator_output_config_test;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  interp_cfg_pkg::bus_req_type bus_in = '0;
  logic [7:0] nv_mode_in = 8'h00, nv_res_in = 8'h00, rdata_out, rd_val, d;
  logic [5:0] nv_ofs_a_in = 6'h00, nv_ofs_b_in = 6'h00;
  interp_cfg_pkg::out_mode_type mode_out;
  logic incremental_out, commutation_out, dir_invert_out, comm_ok;
  logic [8:0] steps_out;
  logic signed [15:0] ofs_a_uv_div_out, ofs_b_uv_div_out;
  logic signed [5:0] ofs_a_steps_out, ofs_b_steps_out;
  int bad_count = 0, check_count = 0, m_mode, m_res, m_a, m_b, v;
  logic [7:0] res_list [4] = '{8'h01, 8'hFF, 8'h80, 8'h5A};
  logic [7:0] trim_list [7] = '{8'h00, 8'h20, 8'h1F, 8'h3F, 8'h21, 8'h01, 8'hC5};
  initial begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  interpolator_output_config i_interpolator_output_config (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .bus_in(bus_in), .nv_mode_in(nv_mode_in), .nv_res_in(nv_res_in),
    .nv_ofs_a_in(nv_ofs_a_in), .nv_ofs_b_in(nv_ofs_b_in), .rdata_out(rdata_out),
    .mode_out(mode_out), .incremental_out(incremental_out), .commutation_out(commutation_out),
    .dir_invert_out(dir_invert_out), .steps_out(steps_out), .ofs_a_uv_div_out(ofs_a_uv_div_out),
    .ofs_b_uv_div_out(ofs_b_uv_div_out), .ofs_a_steps_out(ofs_a_steps_out),
    .ofs_b_steps_out(ofs_b_steps_out));
  motor_counter_model i_motor_counter_model (.mode_in(mode_out), .steps_in(steps_out),
    .comm_ok_out(comm_ok));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic int tsteps(input int c);
    return c[5] ? -(c & 31) : (c & 31);
  endfunction
  // Waits out the two-cycle path to the derived outputs
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    bus_in <= '{addr: a, wdata: dv, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    bus_in <= '0;
    repeat (2) @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    bus_in <= '0;
    @(posedge sys_clk_in);
    q = rdata_out;
  endtask
  task automatic check_all;
    chk("mode", 16'(mode_out), 16'(m_mode & 3));
    chk("class", 16'({incremental_out, commutation_out}), (m_mode & 3) == 3 ? 1 : 2);
    chk("dir", 16'(dir_invert_out), 16'((m_mode & 7) == 6));
    chk("steps", 16'(steps_out), m_res == 0 ? 256 : m_res);
    chk("trim_a", 16'(ofs_a_steps_out), 16'(tsteps(m_a)));
    chk("trim_b", 16'(ofs_b_steps_out), 16'(tsteps(m_b)));
    chk("uv_a", ofs_a_uv_div_out, 16'(tsteps(m_a) * 130));
    chk("uv_b", ofs_b_uv_div_out, 16'(tsteps(m_b) * 130));
    chk("comm_ok", 16'(comm_ok), 16'h0001);
    rd(8'h01, rd_val);
    chk("rd_mode", 16'(rd_val), 16'(m_mode));
    rd(8'h02, rd_val);
    chk("rd_res", 16'(rd_val), 16'(m_res));
    rd(8'h08, rd_val);
    chk("rd_a", 16'(rd_val), 16'(m_a));
    rd(8'h09, rd_val);
    chk("rd_b", 16'(rd_val), 16'(m_b));
    rd(8'h05, rd_val);
    chk("rd_unmapped", 16'(rd_val), 16'h0000);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
  initial begin
    v = $urandom(13);
    m_mode = int'(8'($urandom) & 8'hFC);
    m_res = int'(8'($urandom));
    m_a = int'(6'($urandom));
    m_b = int'(6'($urandom));
    res_list[3] = 8'($urandom);
    nv_mode_in <= 8'(m_mode);
    nv_res_in <= 8'(m_res);
    nv_ofs_a_in <= 6'(m_a);
    nv_ofs_b_in <= 6'(m_b);
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    check_all();
    // Resolution goes to zero before commutation is chosen
    wr(8'h02, 8'h00);
    m_res = 0;
    for (int i = 0; i < 8; i++) begin
      d = (8'($urandom) & 8'hF8) | 8'(i);
      wr(8'h01, d);
      m_mode = d;
      check_all();
    end
    wr(8'h01, 8'h00);
    m_mode = 0;
    for (int k = 0; k < 4; k++) begin
      d = res_list[k];
      wr(8'h02, d);
      m_res = d;
      check_all();
    end
    for (int k = 0; k < 7; k++) begin
      d = trim_list[k];
      v = $urandom;
      wr(8'h08, d);
      wr(8'h09, d ^ 8'(v));
      m_a = d & 8'h3F;
      m_b = (d ^ 8'(v)) & 8'h3F;
      check_all();
    end
    end_sim();
  end
endmodule // interpolator_output_config_test
